// File: bench/halt_and_interrupt_enable_control_tb_top.sv
`timescale 1ns/10ps
module halt_and_interrupt_enable_control_tb_top;
  import hic_pkg::*;
  logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [7:0] mem_data = 0, exec_opcode, fop;
  logic [1:0] fetch_t_state, t0;
  logic [15:0] jump_target;
  logic pready, pslverr, irq_req_n, nmi_req_n, irq_ack, nmi_ack, push_pc;
  logic stop_ack_n, opcode_fetch_cycle, irq_gate_flag, irq_gate_shadow;
  logic parity_flag, bus_hold_request_n = 1, instr_end = 0, mem_sample = 0;
  logic halt_op = 0, enable_irq_op = 0, mask_irq_op = 0;
  logic shadow_restore_return = 0, load_acc_from_vector_base = 0;
  logic load_acc_from_refresh_count = 0, irq_up = 0, nmi_up = 0, clk_run = 1;
  logic [32:0] exp_q[$];
  int fail_count = 0, compares = 0, i;
  hic_halt_ctrl dut (.*);
  hic_periph_model u_periph (.core_clk, .rstn, .irq_up, .nmi_up, .irq_ack,
    .irq_req_n, .nmi_req_n);
  initial begin
    forever #25 if (clk_run) core_clk = ~core_clk;
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
      input logic [31:0] d, input logic [32:0] e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    if (!w) exp_q.push_back(e);
    @(posedge core_clk);
    while (pready !== 1'h1) @(posedge core_clk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb
  // Op strobes only count with instr_end, so they may stay set
  task automatic op(input logic [5:0] o);
    {halt_op, enable_irq_op, mask_irq_op, shadow_restore_return,
      load_acc_from_vector_base, load_acc_from_refresh_count} <= o;
    instr_end <= 1'h1;
    @(posedge core_clk);
    instr_end <= 1'h0;
    @(posedge core_clk);
  endtask : op
  task automatic req(input logic ir, input logic nm);
    irq_up <= ir;
    nmi_up <= nm;
    @(posedge core_clk);
    irq_up <= 1'h0;
    nmi_up <= 1'h0;
    @(posedge core_clk);
  endtask : req
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'h1 && !pwrite)
      chk({pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    void'($urandom(61564));
    fop = 8'($urandom);
    repeat (20) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    chk({irq_gate_flag, irq_gate_shadow, stop_ack_n}, 3'h1);
    apb(1'h1, CTRL_OFF, {24'h0, fop}, 33'h0);
    apb(1'h0, CTRL_OFF, 32'h0, {25'h0, fop});
    apb(1'h0, STAT_OFF, 32'h0, 33'h0);
    apb(1'h0, 12'h008, 32'h0, 33'h100000000);
    // Outside stop the fetched byte is the one executed
    mem_sample <= 1'h1;
    mem_data <= 8'hA5;
    @(posedge core_clk);
    mem_sample <= 1'h0;
    mem_data <= 8'h00;
    @(posedge core_clk);
    chk(exec_opcode, 8'hA5);
    req(1'h1, 1'h0);
    op(6'h10);
    chk({irq_ack, irq_gate_flag, irq_gate_shadow}, 3'h3);
    op(6'h00);
    chk(irq_ack, 1'h1);
    op(6'h00);
    chk({irq_gate_flag, irq_gate_shadow}, 2'h0);
    op(6'h10);
    op(6'h08);
    chk({irq_gate_flag, irq_gate_shadow}, 2'h0);
    req(1'h1, 1'h0);
    op(6'h00);
    chk(irq_ack, 1'h0);
    op(6'h10);
    req(1'h0, 1'h1);
    op(6'h00);
    chk({nmi_ack, irq_ack, push_pc, jump_target}, {3'h5, NMI_TARGET});
    op(6'h00);
    op(6'h02);
    chk({irq_gate_flag, irq_gate_shadow, parity_flag}, 3'h3);
    op(6'h04);
    chk({irq_gate_flag, irq_ack}, 2'h2);
    op(6'h00);
    chk(irq_ack, 1'h1);
    op(6'h00);
    op(6'h01);
    chk({irq_gate_flag, irq_gate_shadow, parity_flag}, 3'h0);
    op(6'h10);
    op(6'h20);
    chk({stop_ack_n, opcode_fetch_cycle}, 2'h1);
    repeat (6) begin
      mem_sample <= 1'h1;
      mem_data <= 8'($urandom);
      @(posedge core_clk);
    end
    mem_sample <= 1'h0;
    chk(exec_opcode, fop);
    t0 = fetch_t_state;
    clk_run = 0;
    #500;
    chk({stop_ack_n, exec_opcode}, {1'h0, fop});
    clk_run = 1;
    @(posedge core_clk);
    chk(fetch_t_state, t0 + 2'h1);
    // Hold blocks both kinds; the edge-latched NMI must survive it
    bus_hold_request_n <= 1'h0;
    req(1'h1, 1'h1);
    repeat (12) @(posedge core_clk);
    chk(stop_ack_n, 1'h0);
    bus_hold_request_n <= 1'h1;
    for (i = 0; i < 20 && !(nmi_ack || irq_ack); i++) @(posedge core_clk);
    chk({stop_ack_n, nmi_ack, irq_ack, irq_gate_flag}, 4'hD);
    finish_test();
  end
endmodule : halt_and_interrupt_enable_control_tb_top

// File: bench/hic_halt_ctrl_properties.sv
`timescale 1ns/10ps
module hic_halt_ctrl_properties (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic irq_req_n,
  input wire logic bus_hold_request_n,
  input wire logic instr_end,
  input wire logic enable_irq_op,
  input wire logic load_acc_from_vector_base,
  input wire logic load_acc_from_refresh_count,
  input wire logic stop_ack_n,
  input wire logic opcode_fetch_cycle,
  input wire logic [1:0] fetch_t_state,
  input wire logic irq_ack,
  input wire logic nmi_ack,
  input wire logic push_pc,
  input wire logic [15:0] jump_target,
  input wire logic irq_gate_flag,
  input wire logic irq_gate_shadow,
  input wire logic parity_flag
);
  import hic_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire run = stop_ack_n && !irq_ack && !nmi_ack;
  wire ldx = load_acc_from_vector_base || load_acc_from_refresh_count;
  sequence s_irq_seen;
    !stop_ack_n && fetch_t_state == T4_IDX && !irq_req_n && irq_gate_flag
      && bus_hold_request_n;
  endsequence
  sequence s_exit;
    !stop_ack_n ##1 (stop_ack_n && (irq_ack || nmi_ack));
  endsequence
  AST_EXIT: assert property (s_irq_seen |=> s_exit)
    else $error("stop exit late");
  AST_STOP_FETCH: assert property (!stop_ack_n |-> opcode_fetch_cycle)
    else $error("stopped without fetch");
  AST_T_WRAP: assert property (!stop_ack_n && fetch_t_state == T4_IDX
    |=> !stop_ack_n && fetch_t_state == 2'h0)
    else $error("fetch state wrap");
  AST_IRQ_GATE: assert property (irq_ack |-> $past(irq_gate_flag))
    else $error("irq taken while gated");
  AST_IRQ_CLR: assert property (irq_ack |=> !irq_gate_flag && !irq_gate_shadow)
    else $error("flags kept after irq");
  AST_NMI_TAKE: assert property (nmi_ack |-> push_pc && jump_target == NMI_TARGET
    ##1 !irq_gate_flag && irq_gate_shadow == $past(irq_gate_shadow))
    else $error("nmi response wrong");
  AST_HOLD: assert property (irq_ack || nmi_ack |-> $past(bus_hold_request_n))
    else $error("taken under bus hold");
  AST_EI_WAIT: assert property (run && instr_end && enable_irq_op |=> !irq_ack)
    else $error("irq right after enable");
  AST_PARITY: assert property (run && instr_end && ldx
    |=> parity_flag == $past(irq_gate_shadow))
    else $error("parity copy wrong");
endmodule : hic_halt_ctrl_properties
bind hic_halt_ctrl hic_halt_ctrl_properties u_props (.*);

// File: bench/hic_periph_model.sv
`timescale 1ns/10ps
module hic_periph_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic irq_up,
  input wire logic nmi_up,
  input wire logic irq_ack,
  output logic irq_req_n,
  output logic nmi_req_n
);
  // Requests move only on a running clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_req_n <= 1'h1;
      nmi_req_n <= 1'h1;
    end else begin
      // Level request held until acknowledged, as a real peripheral does
      if (irq_up) irq_req_n <= 1'h0;
      else if (irq_ack) irq_req_n <= 1'h1;
      nmi_req_n <= !nmi_up;
    end
  end
endmodule : hic_periph_model

// File: core/hic_apb_regs.sv
`timescale 1ns/10ps
module hic_apb_regs (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [hic_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] status_word,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] forced_op_q
);
  import hic_pkg::*;
  logic ctrl_hit;
  logic stat_hit;
  logic access;
  assign ctrl_hit = (paddr == CTRL_OFF);
  assign stat_hit = (paddr == STAT_OFF);
  assign access = psel && penable;
  // Zero wait states; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = access && !ctrl_hit && !stat_hit;
  always_comb begin
    if (ctrl_hit) begin
      prdata = {24'h000000, forced_op_q};
    end else if (stat_hit) begin
      prdata = status_word;
    end else begin
      prdata = 32'h00000000;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      forced_op_q <= FORCED_OP_RST;
    end else if (access && pwrite && ctrl_hit) begin
      forced_op_q <= pwdata[7:0];
    end
  end
endmodule : hic_apb_regs

// File: core/hic_flag_unit.sv
`timescale 1ns/10ps
module hic_flag_unit (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ei_exec,
  input wire logic di_exec,
  input wire logic shadow_restore_return_exec,
  input wire logic ld_ir_exec,
  input wire logic take_irq,
  input wire logic take_nmi,
  output logic gate_q,
  output logic shadow_q,
  output logic parity_q
);
  import hic_pkg::*;
  logic gate_d;
  logic shadow_d;
  // Acceptance last so it overrides the instruction's own effect
  always_comb begin
    gate_d = gate_q;
    shadow_d = shadow_q;
    if (di_exec) begin
      gate_d = 1'b0;
      shadow_d = 1'b0;
    end else if (ei_exec) begin
      gate_d = 1'b1;
      shadow_d = 1'b1;
    end else if (shadow_restore_return_exec) begin
      gate_d = shadow_q;
    end
    if (take_nmi) begin
      gate_d = 1'b0;
    end else if (take_irq) begin
      gate_d = 1'b0;
      shadow_d = 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gate_q <= 1'b0;
      shadow_q <= 1'b0;
      parity_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
      shadow_q <= shadow_d;
      if (ld_ir_exec) begin
        parity_q <= shadow_q;
      end
    end
  end
endmodule : hic_flag_unit

// File: core/hic_halt_ctrl.sv
`timescale 1ns/10ps
module hic_halt_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [hic_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_req_n,
  input wire logic nmi_req_n,
  input wire logic bus_hold_request_n,
  input wire logic instr_end,
  input wire logic halt_op,
  input wire logic enable_irq_op,
  input wire logic mask_irq_op,
  input wire logic shadow_restore_return,
  input wire logic load_acc_from_vector_base,
  input wire logic load_acc_from_refresh_count,
  input wire logic mem_sample,
  input wire logic [7:0] mem_data,
  output logic stop_ack_n,
  output logic opcode_fetch_cycle,
  output logic [1:0] fetch_t_state,
  output logic [7:0] exec_opcode,
  output logic irq_ack,
  output logic nmi_ack,
  output logic push_pc,
  output logic [15:0] jump_target,
  output logic irq_gate_flag,
  output logic irq_gate_shadow,
  output logic parity_flag
);
  import hic_pkg::*;

  hic_state_type state_q;
  hic_state_type state_d;
  logic [1:0] t_q;
  logic [1:0] t_d;
  logic nmi_prev_q;
  logic nmi_pend_q;
  logic nmi_pend_d;
  logic nmi_smp_q;
  logic irq_smp_q;
  logic [7:0] opcode_q;
  logic [15:0] target_q;
  logic [7:0] forced_op;
  logic [31:0] status_word;

  logic in_stop;
  logic in_run;
  logic bus_free;
  logic nmi_fall;
  logic nmi_ok;
  logic irq_ok;
  logic run_end;
  logic run_nmi;
  logic run_irq;
  logic stop_sample;
  logic stop_exit;
  logic take_nmi;
  logic take_irq;
  logic op_load;
  logic ei_exec;
  logic di_exec;
  logic shadow_restore_return_exec;
  logic ld_ir_exec;

  function automatic logic [1:0] next_t(input logic [1:0] t);
    next_t = (t == T4_IDX) ? 2'h0 : 2'(t + 2'h1);
  endfunction : next_t

  // All state is plain flops on core_clk: a held clock freezes
  // everything and a resumed clock carries on untouched
  assign in_stop = (state_q == HIC_STOP);
  // Instruction ends during stop or an acknowledge cycle are ignored
  assign in_run = (state_q == HIC_RUN);
  assign bus_free = bus_hold_request_n;
  assign nmi_fall = nmi_prev_q && !nmi_req_n;

  // No software flag enters the non-maskable path
  assign nmi_ok = nmi_pend_q && bus_free;
  assign irq_ok = !irq_req_n && irq_gate_flag && bus_free;

  assign ei_exec = instr_end && in_run && enable_irq_op;
  assign di_exec = instr_end && in_run && mask_irq_op;
  assign shadow_restore_return_exec = instr_end && in_run && shadow_restore_return;
  assign ld_ir_exec = instr_end && in_run &&
    (load_acc_from_vector_base || load_acc_from_refresh_count);

  // End of an ordinary instruction; halt goes to stop instead
  assign run_end = (state_q == HIC_RUN) && instr_end && !halt_op;
  assign run_nmi = run_end && nmi_ok;
  // Ending enable or disable op cannot let a maskable request in
  assign run_irq = run_end && !nmi_ok && irq_ok &&
    !enable_irq_op && !mask_irq_op;

  // Request inputs looked at only in the fourth fetch state
  assign stop_sample = in_stop && (t_q == T4_IDX);
  assign stop_exit = in_stop && (nmi_smp_q || irq_smp_q);

  assign take_nmi = (state_q == HIC_ACK_NMI);
  assign take_irq = (state_q == HIC_ACK_IRQ);

  always_comb begin
    state_d = state_q;
    case (state_q)
      HIC_RUN: begin
        if (run_nmi) begin
          state_d = HIC_ACK_NMI;
        end else if (run_irq) begin
          state_d = HIC_ACK_IRQ;
        end else if (instr_end && halt_op) begin
          state_d = HIC_STOP;
        end
      end
      HIC_STOP: begin
        if (stop_exit) begin
          // Kind sampled decides the acknowledge
          if (nmi_smp_q) begin
            state_d = HIC_ACK_NMI;
          end else begin
            state_d = HIC_ACK_IRQ;
          end
        end
      end
      HIC_ACK_NMI: begin
        state_d = HIC_RUN;
      end
      HIC_ACK_IRQ: begin
        state_d = HIC_RUN;
      end
      default: begin
        state_d = HIC_RUN;
      end
    endcase
  end

  // Fetch states run only while stopped, restart at T1 on entry
  assign t_d = in_stop && !stop_exit ? next_t(t_q) : 2'h0;

  // Set beats clear: a new edge in the accept cycle stays pending
  assign nmi_pend_d = nmi_fall || (nmi_pend_q && !take_nmi);

  // In stop the fetched byte is dropped for the forced opcode
  assign op_load = (in_stop && t_q == T3_IDX) ||
    (!in_stop && mem_sample);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= HIC_RUN;
      t_q <= 2'h0;
    end else begin
      state_q <= state_d;
      t_q <= t_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_req_n;
      nmi_pend_q <= nmi_pend_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nmi_smp_q <= 1'b0;
      irq_smp_q <= 1'b0;
    end else if (stop_sample) begin
      nmi_smp_q <= nmi_ok;
      irq_smp_q <= !nmi_ok && irq_ok;
    end else if (!in_stop) begin
      nmi_smp_q <= 1'b0;
      irq_smp_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      opcode_q <= FORCED_OP_RST;
    end else if (op_load) begin
      opcode_q <= in_stop ? forced_op : mem_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      target_q <= 16'h0000;
    end else if (run_nmi || (stop_exit && nmi_smp_q)) begin
      target_q <= NMI_TARGET;
    end
  end

  hic_flag_unit u_flags (
    .core_clk(core_clk),
    .rstn(rstn),
    .ei_exec(ei_exec),
    .di_exec(di_exec),
    .shadow_restore_return_exec(shadow_restore_return_exec),
    .ld_ir_exec(ld_ir_exec),
    .take_irq(take_irq),
    .take_nmi(take_nmi),
    .gate_q(irq_gate_flag),
    .shadow_q(irq_gate_shadow),
    .parity_q(parity_flag)
  );

  always_comb begin
    status_word = 32'h00000000;
    status_word[ST_STOPPED] = in_stop;
    status_word[ST_GATE] = irq_gate_flag;
    status_word[ST_SHADOW] = irq_gate_shadow;
    status_word[ST_NMI_PEND] = nmi_pend_q;
    status_word[ST_PARITY] = parity_flag;
    status_word[ST_T_LSB +: 2] = t_q;
  end

  hic_apb_regs u_regs (
    .core_clk(core_clk),
    .rstn(rstn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .status_word(status_word),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .forced_op_q(forced_op)
  );

  // Acknowledge falls with the state register, not a cycle later
  assign stop_ack_n = !in_stop;
  assign opcode_fetch_cycle = in_stop;
  assign fetch_t_state = t_q;
  assign exec_opcode = opcode_q;
  assign irq_ack = take_irq;
  assign nmi_ack = take_nmi;
  assign push_pc = take_nmi;
  assign jump_target = target_q;
endmodule : hic_halt_ctrl

// File: core/hic_pkg.sv
// Functional notes
// - In stop state keep fetching, drop memory byte, execute forced no-op; the code executes the CTRL forced opcode, 00h after reset but writable.
// - In stop state sample both request inputs at the fourth fetch state.
// - Leave stop next edge on sampled non-maskable, or maskable with gate set.
// - After stop exit run the acknowledge matching the accepted request kind.
// - Both requests together: non-maskable is acknowledged first.
// - Stop acknowledge output is active for the whole stop state.
// - Stopped clock at either level freezes all registers and outputs.
// - Clock resuming continues from the suspended point, no reinitialisation.
// - Non-maskable request is accepted except under bus hold; no software flag blocks it.
// - Enable op sets gate and shadow; disable op clears both.
// - Reset clears gate and shadow flags.
// - After enable op, maskable request refused until next instruction ends.
// - Maskable acceptance clears gate and shadow flags.
// - Non-maskable acceptance clears gate, keeps shadow.
// - Accumulator loads from vector base or refresh copy shadow to parity.
// - Non-maskable return copies shadow into gate.
// - Non-maskable response pushes program counter and jumps to 0066H.
// - While bus hold is requested, neither request kind is accepted.
package hic_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFF = 12'h004;
  localparam logic [7:0] FORCED_OP_RST = 8'h00;
  localparam logic [15:0] NMI_TARGET = 16'h0066;
  localparam logic [1:0] T3_IDX = 2'h2;
  localparam logic [1:0] T4_IDX = 2'h3;
  localparam int ST_STOPPED = 0;
  localparam int ST_GATE = 1;
  localparam int ST_SHADOW = 2;
  localparam int ST_NMI_PEND = 3;
  localparam int ST_PARITY = 4;
  localparam int ST_T_LSB = 8;
  typedef enum logic [1:0] {
    HIC_RUN = 2'b00,
    HIC_STOP = 2'b01,
    HIC_ACK_NMI = 2'b10,
    HIC_ACK_IRQ = 2'b11
  } hic_state_type;
endpackage : hic_pkg
